// ---- bench/srd_host_model.sv ----
`timescale 1ns/100ps
// Host controller: every pin level holds three cycles so the synchronisers see it.
module srd_host_model
    import srd_pkg::*;
(
    input wire logic mclk,
    output logic     serClk,
    output logic     serData,
    output logic     strobe,
    input wire logic serOutNext
);
    logic [srd_pkg::CHAIN_BITS-1:0] outWord;  // Bits that left the far end.
    initial begin
        serClk = 1'b0;
        serData = 1'b0;
        strobe = 1'b0;
        outWord = '0;
    end
    task automatic hold3;
        repeat (3) @(posedge mclk);
    endtask
    // Shifts a word most significant bit first; the strobe stays low throughout.
    task automatic send(input logic [srd_pkg::CHAIN_BITS-1:0] w);
        @(posedge mclk);
        for (int i = CHAIN_BITS - 1; i >= 0; i--) begin
            serData <= w[i];
            hold3();
            // The overflow bit is taken before the edge that shifts it away.
            outWord <= {outWord[CHAIN_BITS-2:0], serOutNext};
            serClk <= 1'b1;
            hold3();
            serClk <= 1'b0;
            hold3();
        end
        serData <= ~w[0];  // A released line must not look like a held bit.
    endtask
    // Ends an update with one strobe pulse.
    task automatic latch;
        @(posedge mclk);
        strobe <= 1'b1;
        hold3();
        strobe <= 1'b0;
        hold3();
    endtask
    // Solid-state paths only for internal scan of the pair alone on one function.
    function automatic logic [23:0] pick(input logic intScan, input logic pairOnly,
                                         input logic sameFn);
        pick = (intScan && pairOnly && sameFn) ? 24'h001800 : 24'h000210;
    endfunction
endmodule

// ---- bench/srd_relay_chain_asserts.sv ----
`timescale 1ns/100ps
// Watches the relay chain pins; sync delays are allowed a few cycles of slack.
module srd_relay_chain_asserts
    import srd_pkg::*;
(
    // Clock and reset
    input wire logic                          mclk,
    input wire logic                          rst,
    // Serial bus and supervisor
    input wire logic                          serClk,
    input wire logic                          serData,
    input wire logic                          strobe,
    input wire logic                          serOutNext,
    input wire logic                          powerSupervisorHold,
    // Driver outputs and update flag
    input wire logic [srd_pkg::INPUT_RELAYS-1:0] inputRelayN,
    input wire logic                          poleConfigRelayN,
    input wire logic                          ch5LatchingRelayN,
    input wire logic                          ch10LatchingRelayN,
    input wire logic                          ch5SolidStateSwitchN,
    input wire logic                          ch10SolidStateSwitchN,
    input wire logic [srd_pkg::CHAIN_BITS-1:0] driverN,
    input wire logic                          updateDone
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // A strobe rise, and a stretch with no strobe and no supervisor hold.
    sequence strobeRise; !strobe ##1 strobe; endsequence
    sequence quietBus; (!strobe && !powerSupervisorHold) [*6]; endsequence
    reset_outputs_a: assert property ($fell(rst) |-> &driverN && !updateDone)
        else $error("drivers not idle after reset");
    hold_blocks_a: assert property (powerSupervisorHold [*5] |-> &driverN)
        else $error("driver active under supervisor hold");
    quiet_stable_a: assert property (quietBus |=> $stable(driverN))
        else $error("drivers moved without strobe");
    relay_map_a: assert property (inputRelayN == driverN[9:0]
        && poleConfigRelayN == driverN[POLE_CONFIG_BIT] && ch5LatchingRelayN == driverN[CH5_RELAY_BIT]
        && ch10LatchingRelayN == driverN[CH10_RELAY_BIT] && ch5SolidStateSwitchN == driverN[CH5_SSW_BIT]
        && ch10SolidStateSwitchN == driverN[CH10_SSW_BIT]) else $error("relay pin map wrong");
    strobe_done_a: assert property (strobeRise |-> ##[2:6] updateDone)
        else $error("no update after strobe");
    done_width_a: assert property (updateDone |=> !updateDone)
        else $error("update flag too long");
    done_cause_a: assert property (!strobe [*8] |-> !updateDone)
        else $error("update flag without strobe");
    serout_idle_a: assert property (!serClk [*5] |=> $stable(serOutNext))
        else $error("chain output moved without clock");
endmodule
bind srd_relay_chain srd_relay_chain_asserts chk_i (.mclk(mclk), .rst(rst), .serClk(serClk),
    .serData(serData), .strobe(strobe), .serOutNext(serOutNext),
    .powerSupervisorHold(powerSupervisorHold), .inputRelayN(inputRelayN),
    .poleConfigRelayN(poleConfigRelayN), .ch5LatchingRelayN(ch5LatchingRelayN),
    .ch10LatchingRelayN(ch10LatchingRelayN), .ch5SolidStateSwitchN(ch5SolidStateSwitchN),
    .ch10SolidStateSwitchN(ch10SolidStateSwitchN), .driverN(driverN), .updateDone(updateDone));

// ---- bench/tb.sv ----
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; $display("BAD %0t mismatch", $time); end end
module tb;
    import srd_pkg::*;
    logic        mclk, rst, hold, serClk, serData, strobe, serOut, done;
    logic        pole, ch5R, ch10R, ch5S, ch10S;
    logic [9:0]  inRel;
    logic [23:0] drvN;
    int          fails = 0, checks = 0, cycles = 0;
    srd_relay_chain srd_relay_chain_i (.mclk(mclk), .rst(rst), .serClk(serClk),
        .serData(serData), .strobe(strobe), .serOutNext(serOut), .powerSupervisorHold(hold),
        .inputRelayN(inRel), .poleConfigRelayN(pole), .ch5LatchingRelayN(ch5R),
        .ch10LatchingRelayN(ch10R), .ch5SolidStateSwitchN(ch5S),
        .ch10SolidStateSwitchN(ch10S), .driverN(drvN), .updateDone(done));
    srd_host_model srd_host_model_i (.mclk(mclk), .serClk(serClk), .serData(serData),
        .strobe(strobe), .serOutNext(serOut));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // A hung wait is cut off well past the longest expected run.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 6000) begin
            fails++;
            complete_run();
        end
    end
    task automatic complete_run;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic upd(input logic [23:0] w);
        srd_host_model_i.send(w);
        srd_host_model_i.latch();
        @(negedge mclk);
    endtask
    task automatic t_update;
        srd_host_model_i.send(24'ha5c381);
        @(negedge mclk);
        `CHK(drvN, 24'hffffff)
        srd_host_model_i.latch();
        @(negedge mclk);
        `CHK(drvN, ~24'ha5c381)
    endtask
    task automatic t_chain;
        upd(24'h3c0f96);
        `CHK(srd_host_model_i.outWord, 24'ha5c381)
        `CHK(drvN, ~24'h3c0f96)
    endtask
    task automatic t_map;
        upd(srd_host_model_i.pick(1'b1, 1'b1, 1'b1));
        `CHK({ch5S, ch10S, ch5R, ch10R}, 4'h3)
        upd(srd_host_model_i.pick(1'b1, 1'b0, 1'b1));
        `CHK({ch5S, ch10S, ch5R, ch10R}, 4'hc)
        `CHK({pole, inRel}, 11'h5ef)
        upd(24'h000400);
        `CHK({pole, inRel}, 11'h3ff)
    endtask
    // A reset in mid-run must drop every driver and empty the chain.
    task automatic t_reset;
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(negedge mclk);
        `CHK({drvN, serOut}, {24'hffffff, 1'b0})
        upd(24'h81c3a5);
        `CHK(srd_host_model_i.outWord, 24'h000000)
        `CHK(drvN, ~24'h81c3a5)
    endtask
    task automatic t_hold;
        @(posedge mclk);
        hold <= 1'b1;
        upd(24'h000fff);
        `CHK(drvN, 24'hffffff)
        @(posedge mclk);
        hold <= 1'b0;
        repeat (6) @(negedge mclk);
        `CHK(drvN, ~24'h000fff)
    endtask
    initial begin
        rst = 1'b1;
        hold = 1'b0;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(negedge mclk);
        `CHK({drvN, done}, {24'hffffff, 1'b0})
        t_update();
        t_chain();
        t_map();
        t_hold();
        t_reset();
        complete_run();
    end
endmodule

// ---- logic/srd_pkg.sv ----
package srd_pkg;
    // ------------------------------------------------------------
    // Chain geometry
    // ------------------------------------------------------------
    localparam int STAGE_BITS  = 8;
    localparam int STAGE_COUNT = 3;
    localparam int CHAIN_BITS  = STAGE_BITS * STAGE_COUNT;
    localparam int RELAY_COUNT = 11;
    localparam int INPUT_RELAYS = 10;

    // ------------------------------------------------------------
    // Relay positions in the latched word
    // ------------------------------------------------------------
    localparam int POLE_CONFIG_BIT = 10;
    localparam int CH5_RELAY_BIT   = 4;
    localparam int CH10_RELAY_BIT  = 9;
    localparam int CH5_SSW_BIT     = 11;
    localparam int CH10_SSW_BIT    = 12;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [STAGE_BITS-1:0] STAGE_RESET  = 8'h00;
    localparam logic [1:0]            SYNC_RESET   = 2'h0;
    localparam logic [1:0]            SYNC_OE_RST  = 2'h3;

    typedef enum logic [0:0] {
        SRD_IDLE = 1'b0,
        SRD_SHIFTING = 1'b1
    } srd_phase_t;
endpackage

// ---- logic/srd_relay_chain.sv ----
`timescale 1ns/100ps
// Function
// - Three bytes shift in, one bit per clock.
// - Each stage overflows into the next stage; the last one drives serOutNext.
// - A strobe rise copies shifted state to latches.
// - Driver output low energizes its relay.
// - Latched state reaches relays only when enabled.
// - Supervisor holds enables inactive around power changes.
// - Ten input relays plus one pole relay.
// - Strobe pulse ends each relay update.
module srd_relay_chain
    import srd_pkg::*;
(
    // Clock and reset
    input  wire logic                       mclk,
    input  wire logic                       rst,
    // Serial relay bus pins
    input  wire logic                       serClk,
    input  wire logic                       serData,
    input  wire logic                       strobe,
    output logic                            serOutNext,
    // Supervisor input, high while supply is unsafe
    input  wire logic                       powerSupervisorHold,
    // Relay driver outputs, active low
    output logic [srd_pkg::INPUT_RELAYS-1:0] inputRelayN,
    output logic                            poleConfigRelayN,
    output logic                            ch5LatchingRelayN,
    output logic                            ch10LatchingRelayN,
    output logic                            ch5SolidStateSwitchN,
    output logic                            ch10SolidStateSwitchN,
    output logic [srd_pkg::CHAIN_BITS-1:0]  driverN,
    // Status
    output logic                            updateDone
);
    import srd_pkg::*;

    typedef struct packed {
        logic [1:0] clkSync;
        logic [1:0] datSync;
        logic [1:0] stbSync;
        logic [1:0] holdSync;
        logic       clkPrev;
        logic       stbPrev;
        logic       datHeld;
        logic       done;
    } srd_st_t;

    srd_st_t st_reg;
    srd_st_t st_next;

    srd_stage_if ctl ();
    logic [STAGE_COUNT:0] chainLink;
    logic clkRise;
    logic stbRise;

    // ------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ------------------------------------------------------------
    // Edges are taken from the second flop only, so a metastable first
    // flop never reaches the shift logic.
    assign clkRise = st_reg.clkSync[1] & ~st_reg.clkPrev;
    assign stbRise = st_reg.stbSync[1] & ~st_reg.stbPrev;

    always_comb begin
        st_next = st_reg;
        st_next.clkSync  = {st_reg.clkSync[0], serClk};
        st_next.datSync  = {st_reg.datSync[0], serData};
        st_next.stbSync  = {st_reg.stbSync[0], strobe};
        st_next.holdSync = {st_reg.holdSync[0], powerSupervisorHold};
        st_next.clkPrev  = st_reg.clkSync[1];
        st_next.stbPrev  = st_reg.stbSync[1];
        st_next.datHeld  = st_reg.datSync[1];
        // The done pulse marks the strobe that closes an update sequence.
        st_next.done     = stbRise;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_reg <= '{clkSync: SYNC_RESET, datSync: SYNC_RESET,
                        stbSync: SYNC_RESET, holdSync: SYNC_OE_RST,
                        clkPrev: 1'b0, stbPrev: 1'b0, datHeld: 1'b0,
                        done: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Stage control
    // ------------------------------------------------------------
    // Data sampled a cycle ahead of the edge gives the host setup margin.
    assign ctl.shiftEn = clkRise;
    assign ctl.latchEn = stbRise;
    // Enables stay inactive while the supervisor holds, and from reset.
    assign ctl.outEnN  = st_reg.holdSync[1] | rst;

    // ------------------------------------------------------------
    // Driver chain
    // ------------------------------------------------------------
    assign chainLink[0] = st_reg.datHeld;

    genvar g;
    generate
        for (g = 0; g < STAGE_COUNT; g++) begin : gStage
            srd_stage uStage (
                .mclk   (mclk),
                .rst    (rst),
                .ctl    (ctl),
                .serIn  (chainLink[g]),
                .serOut (chainLink[g+1]),
                .drvN   (driverN[g*STAGE_BITS +: STAGE_BITS])
            );
        end
    endgenerate

    assign serOutNext = chainLink[STAGE_COUNT];

    // ------------------------------------------------------------
    // Relay mapping
    // ------------------------------------------------------------
    // Ten input relays, then the pole relay; the host decides when the
    // solid-state paths for channels 5 and 10 are used.
    assign inputRelayN           = driverN[INPUT_RELAYS-1:0];
    assign poleConfigRelayN      = driverN[POLE_CONFIG_BIT];
    assign ch5LatchingRelayN     = driverN[CH5_RELAY_BIT];
    assign ch10LatchingRelayN    = driverN[CH10_RELAY_BIT];
    assign ch5SolidStateSwitchN  = driverN[CH5_SSW_BIT];
    assign ch10SolidStateSwitchN = driverN[CH10_SSW_BIT];
    assign updateDone            = st_reg.done;
endmodule

// ---- logic/srd_stage.sv ----
`timescale 1ns/100ps
// One eight-bit shift/latch driver stage with active-low outputs.
module srd_stage
    import srd_pkg::*;
(
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst,
    // Shared control
    srd_stage_if.stage                 ctl,
    // Serial path
    input  wire logic                  serIn,
    output logic                       serOut,
    // Driver outputs
    output logic [srd_pkg::STAGE_BITS-1:0] drvN
);
    import srd_pkg::*;

    typedef struct packed {
        logic [STAGE_BITS-1:0] shiftR;
        logic [STAGE_BITS-1:0] latchR;
    } srd_stage_st_t;

    srd_stage_st_t st_reg;
    srd_stage_st_t st_next;

    // ------------------------------------------------------------
    // Shift and latch
    // ------------------------------------------------------------
    // Shift on each data clock; copy to the latch on the strobe.
    always_comb begin
        st_next = st_reg;
        if (ctl.shiftEn) begin
            st_next.shiftR = {st_reg.shiftR[STAGE_BITS-2:0], serIn};
        end
        if (ctl.latchEn) begin
            st_next.latchR = st_reg.shiftR;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_reg <= '{shiftR: STAGE_RESET, latchR: STAGE_RESET};
        end else begin
            st_reg <= st_next;
        end
    end

    // Overflow bit feeds the next stage in the chain.
    assign serOut = st_reg.shiftR[STAGE_BITS-1];
    // Low energizes; with enable inactive every driver rests high.
    assign drvN = ctl.outEnN ? {STAGE_BITS{1'b1}} : ~st_reg.latchR;
endmodule

// ---- logic/srd_stage_if.sv ----
`timescale 1ns/100ps
// Signals shared by every driver stage: shift and latch strobes and the output enable.
interface srd_stage_if;
    logic shiftEn;
    logic latchEn;
    logic outEnN;
    modport ctrl  (output shiftEn, output latchEn, output outEnN);
    modport stage (input shiftEn, input latchEn, input outEnN);
endinterface
